// File: hdl/tcri_pkg.sv
package tcri_pkg;

  // ********************************************************
  // register indices on the processor byte port
  // ********************************************************
  localparam int unsigned TCRI_ADDR_W     = 3;
  localparam logic [2:0]  TCRI_CTRL_A_IDX = 3'h0;
  localparam logic [2:0]  TCRI_CTRL_C_IDX = 3'h1;
  localparam logic [2:0]  TCRI_CNT_LO_IDX = 3'h2;
  localparam logic [2:0]  TCRI_CNT_HI_IDX = 3'h3;
  localparam logic [2:0]  TCRI_CMP_A_IDX  = 3'h4;
  localparam logic [2:0]  TCRI_CMP_B_IDX  = 3'h5;

  // ********************************************************
  // control register a field positions
  // ********************************************************
  localparam int unsigned TCRI_WIDTH_SELECT_BIT  = 7;
  localparam int unsigned TCRI_CAPTURE_EN_BIT    = 6;
  localparam int unsigned TCRI_NOISE_FILTER_BIT  = 5;
  localparam int unsigned TCRI_EDGE_SELECT_BIT   = 4;
  localparam int unsigned TCRI_WAVEFORM_MODE_BIT = 0;

  // writable bits; bits 2:1 of a and 7:2 of c read back zero
  localparam logic [7:0] TCRI_CTRL_A_MASK  = 8'hf9;
  localparam logic [7:0] TCRI_CTRL_C_MASK  = 8'h03;
  localparam logic [7:0] TCRI_BYTE_RESET   = 8'h00;
  localparam logic [15:0] TCRI_COUNT_RESET = 16'h0000;

  // ********************************************************
  // capture sources and filter depth
  // ********************************************************
  localparam logic [1:0]  TCRI_SRC_PIN     = 2'h0;
  localparam logic [1:0]  TCRI_SRC_RX_DONE = 2'h1;
  localparam logic [1:0]  TCRI_SRC_TX_DONE = 2'h2;
  localparam int unsigned TCRI_FILTER_SAMPLES = 4;

  typedef enum logic {
    TCRI_WAVE_NORMAL,
    TCRI_WAVE_CLEAR_ON_MATCH
  } tcri_wave_t;

endpackage

// File: hdl/tcri_cap_if.sv
`timescale 1ns/1ns
// capture front end: selected source in, qualified edge out
interface tcri_cap_if;
  logic filter_en;
  logic edge_rising;
  logic src_level;
  logic capture_event;

  modport front (input filter_en, input edge_rising, input src_level, output capture_event);
  modport core  (output filter_en, output edge_rising, output src_level, input capture_event);
endinterface

// File: hdl/tcri_capture_front.sv
`timescale 1ns/1ns
module tcri_capture_front
  import tcri_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   sys_rst,
  tcri_cap_if.front   cap
);

  typedef struct packed {
    logic [TCRI_FILTER_SAMPLES-1:0] hist;
    logic                           filt;
    logic                           prev;
    logic                           event_out;
  } tcri_front_t;

  tcri_front_t st_reg;
  tcri_front_t st_next;

  // ********************************************************
  // noise filter and edge detector
  // ********************************************************
  // with the filter on, output moves only on a full run of equal samples
  always_comb begin
    st_next      = st_reg;
    st_next.hist = {st_reg.hist[TCRI_FILTER_SAMPLES-2:0], cap.src_level};
    if (cap.filter_en) begin
      if (&st_reg.hist) begin
        st_next.filt = 1'b1;
      end else if (~|st_reg.hist) begin
        st_next.filt = 1'b0;
      end
    end else begin
      st_next.filt = cap.src_level;
    end
    st_next.prev = st_reg.filt;
    // polarity picks the trigger edge
    st_next.event_out = cap.edge_rising ? (st_reg.filt & ~st_reg.prev)
                                        : (~st_reg.filt & st_reg.prev);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cap.capture_event = st_reg.event_out;

  property p_filter_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      (cap.filter_en && !(&st_reg.hist) && (|st_reg.hist)) |=> (st_reg.filt == $past(st_reg.filt));
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("filter output moved early");

  property p_edge_polarity;
    @(posedge sys_clk) disable iff (sys_rst)
      (cap.edge_rising && st_reg.filt && !st_reg.prev) |=> st_reg.event_out;
  endproperty
  a_edge_polarity: assert property (p_edge_polarity) else $error("rising edge not seen");

endmodule

// File: hdl/tcri_timer.sv
`timescale 1ns/1ns
// Function
// - one 8-bit high-byte holding register shared by counter and compare pairs
// - high byte written first; low write commits both, 16-bit counter or capture-mode compare low read latches high
// - the holding register keeps its value after a low-byte write
// - width bit 7 makes counter 16 bits and merges the two compares
// - bit 6 enables input capture mode
// - bit 5 filter needs four equal samples before output changes
// - bit 4 picks capture edge, zero falling, one rising
// - capture copies counter into capture value and sets capture flag
// - bits 2:1 of control a and 7:2 of control c read zero
// - bit 0 selects counting sequence and top value source
// - control c bits 1:0 select capture source; interrupt needs enable
// - source 00 pin, 01 serial rx done, 10 serial tx done, 11 none
// - counter write blocks compare match flags on the next timer tick
// - 16-bit counter is low byte plus high byte through the latch
// - 8-bit mode compares compare a with counter low byte
// - compare b meets counter low byte in 8-bit, high byte in 16-bit
// - 16-bit compare is b high, a low, written through the latch
// - 16-bit match sets only compare flag a
module tcri_timer
  import tcri_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire logic [TCRI_ADDR_W-1:0] reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [7:0]             reg_wdata,
  output logic      [7:0]             reg_rdata,
  input  wire logic                   timer_tick,
  input  wire logic                   capture_pin,
  input  wire logic                   serial_rx_done_source,
  input  wire logic                   serial_tx_done_source,
  input  wire logic                   capture_interrupt_enable,
  input  wire logic                   capture_flag_clear,
  input  wire logic [1:0]             compare_flag_clear,
  output logic                        capture_flag,
  output logic                        compare_flag_a,
  output logic                        compare_flag_b,
  output logic                        capture_irq
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [1:0]  ctrl_c;
    logic [15:0] count;
    logic [7:0]  cmp_a;
    logic [7:0]  cmp_b;
    logic [7:0]  temp;
    logic        block_match;
    logic        pin_meta;
    logic        pin_sync;
    logic [7:0]  rdata;
    logic        cap_flag;
    logic        cmp_flag_a;
    logic        cmp_flag_b;
    logic        cap_irq;
  } tcri_state_t;

  tcri_state_t st_reg;
  tcri_state_t st_next;

  tcri_cap_if cap ();

  // one access decoder for the write strobes; reads decode the index in a case
  function automatic logic hit(input logic strobe, input logic [TCRI_ADDR_W-1:0] addr,
                               input logic [TCRI_ADDR_W-1:0] idx);
    hit = strobe && (addr == idx);
  endfunction

  logic        wide;
  logic        cap_mode;
  tcri_wave_t  wave;
  logic        wr_cnt_lo;
  logic        wr_cnt_hi;
  logic        wr_cmp_a;
  logic        wr_cmp_b;
  logic        match_a;
  logic        match_b;
  logic        match_ok;
  logic        src_level;
  logic [15:0] count_inc;

  // ********************************************************
  // mode decode and comparators
  // ********************************************************
  always_comb begin
    wide      = st_reg.ctrl_a[TCRI_WIDTH_SELECT_BIT];
    cap_mode  = st_reg.ctrl_a[TCRI_CAPTURE_EN_BIT];
    wave      = st_reg.ctrl_a[TCRI_WAVEFORM_MODE_BIT] ? TCRI_WAVE_CLEAR_ON_MATCH
                                                      : TCRI_WAVE_NORMAL;
    wr_cnt_lo = hit(reg_wr, reg_addr, TCRI_CNT_LO_IDX);
    wr_cnt_hi = hit(reg_wr, reg_addr, TCRI_CNT_HI_IDX);
    wr_cmp_a  = hit(reg_wr, reg_addr, TCRI_CMP_A_IDX);
    wr_cmp_b  = hit(reg_wr, reg_addr, TCRI_CMP_B_IDX);
    // 16-bit: b is the high byte of one compare; 8-bit: two compares
    if (wide) begin
      match_a = (st_reg.count == {st_reg.cmp_b, st_reg.cmp_a});
      match_b = 1'b0;
    end else begin
      match_a = (st_reg.count[7:0] == st_reg.cmp_a);
      match_b = (st_reg.count[7:0] == st_reg.cmp_b);
    end
    // registers act as capture storage in capture mode, so no match flags then
    match_ok  = timer_tick && !st_reg.block_match && !cap_mode;
    count_inc = wide ? (st_reg.count + 16'h0001)
                     : {8'h00, st_reg.count[7:0] + 8'h01};
  end

  // capture source mux; the pin is only read after its second stage
  always_comb begin
    case (st_reg.ctrl_c)
      TCRI_SRC_PIN:     src_level = st_reg.pin_sync;
      TCRI_SRC_RX_DONE: src_level = serial_rx_done_source;
      TCRI_SRC_TX_DONE: src_level = serial_tx_done_source;
      default:          src_level = 1'b0;
    endcase
  end

  assign cap.filter_en   = st_reg.ctrl_a[TCRI_NOISE_FILTER_BIT];
  assign cap.edge_rising = st_reg.ctrl_a[TCRI_EDGE_SELECT_BIT];
  assign cap.src_level   = src_level;

  tcri_capture_front u_front (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .cap     (cap.front)
  );

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    st_next          = st_reg;
    st_next.pin_meta = capture_pin;
    st_next.pin_sync = st_reg.pin_meta;

    // control registers; reserved read-zero bits never stored
    if (hit(reg_wr, reg_addr, TCRI_CTRL_A_IDX)) begin
      st_next.ctrl_a = reg_wdata & TCRI_CTRL_A_MASK;
    end
    if (hit(reg_wr, reg_addr, TCRI_CTRL_C_IDX)) begin
      st_next.ctrl_c = reg_wdata[1:0];
    end

    // high-byte writes park in the shared latch
    if (wr_cnt_hi || (wr_cmp_b && wide)) begin
      st_next.temp = reg_wdata;
    end

    // counter: processor write wins over the tick
    if (wr_cnt_lo) begin
      st_next.count = wide ? {st_reg.temp, reg_wdata} : {8'h00, reg_wdata};
    end else if (timer_tick) begin
      if (wave == TCRI_WAVE_CLEAR_ON_MATCH && match_a) begin
        st_next.count = TCRI_COUNT_RESET;
      end else begin
        st_next.count = count_inc;
      end
    end

    // any counter write arms the block; the next tick consumes it
    if (wr_cnt_lo || wr_cnt_hi) begin
      st_next.block_match = 1'b1;
    end else if (timer_tick) begin
      st_next.block_match = 1'b0;
    end

    // compare writes; 16-bit low write commits latch as high byte
    if (wr_cmp_a) begin
      st_next.cmp_a = reg_wdata;
      if (wide) begin
        st_next.cmp_b = st_reg.temp;
      end
    end
    if (wr_cmp_b && !wide) begin
      st_next.cmp_b = reg_wdata;
    end

    // capture overrides a processor write in the same cycle
    if (cap_mode && cap.capture_event) begin
      st_next.cmp_a = st_reg.count[7:0];
      if (wide) begin
        st_next.cmp_b = st_reg.count[15:8];
      end
    end

    // sticky flags: a set in the clear cycle wins
    if (capture_flag_clear) begin
      st_next.cap_flag = 1'b0;
    end
    if (cap_mode && cap.capture_event) begin
      st_next.cap_flag = 1'b1;
    end
    if (compare_flag_clear[0]) begin
      st_next.cmp_flag_a = 1'b0;
    end
    if (match_ok && match_a) begin
      st_next.cmp_flag_a = 1'b1;
    end
    if (compare_flag_clear[1]) begin
      st_next.cmp_flag_b = 1'b0;
    end
    if (match_ok && match_b) begin
      st_next.cmp_flag_b = 1'b1;
    end
    st_next.cap_irq = st_next.cap_flag && capture_interrupt_enable;

    // reads; a 16-bit low-byte read snapshots the high byte into the latch
    if (reg_rd) begin
      case (reg_addr)
        TCRI_CTRL_A_IDX: st_next.rdata = st_reg.ctrl_a & TCRI_CTRL_A_MASK;
        TCRI_CTRL_C_IDX: st_next.rdata = {6'h00, st_reg.ctrl_c};
        TCRI_CNT_LO_IDX: begin
          st_next.rdata = st_reg.count[7:0];
          if (wide) begin
            st_next.temp = st_reg.count[15:8];
          end
        end
        TCRI_CNT_HI_IDX: st_next.rdata = wide ? st_reg.temp : st_reg.count[15:8];
        TCRI_CMP_A_IDX: begin
          st_next.rdata = st_reg.cmp_a;
          // only captured values need the snapshot; fixed compares read direct
          if (wide && cap_mode) begin
            st_next.temp = st_reg.cmp_b;
          end
        end
        TCRI_CMP_B_IDX:  st_next.rdata = (wide && cap_mode) ? st_reg.temp : st_reg.cmp_b;
        default:         st_next.rdata = TCRI_BYTE_RESET;
      endcase
    end
  end

  // ********************************************************
  // state register
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata      = st_reg.rdata;
  assign capture_flag   = st_reg.cap_flag;
  assign compare_flag_a = st_reg.cmp_flag_a;
  assign compare_flag_b = st_reg.cmp_flag_b;
  assign capture_irq    = st_reg.cap_irq;

  // ********************************************************
  // checks
  // ********************************************************
  property p_low_write_commit;
    @(posedge sys_clk) disable iff (sys_rst)
      (wide && wr_cnt_lo) |=> (st_reg.count == {$past(st_reg.temp), $past(reg_wdata)});
  endproperty
  a_low_write_commit: assert property (p_low_write_commit) else $error("16-bit commit wrong");

  property p_latch_kept;
    @(posedge sys_clk) disable iff (sys_rst)
      (wr_cnt_lo && !reg_rd) |=> (st_reg.temp == $past(st_reg.temp));
  endproperty
  a_latch_kept: assert property (p_latch_kept) else $error("latch changed on low write");

  property p_low_read_snap;
    @(posedge sys_clk) disable iff (sys_rst)
      (wide && hit(reg_rd, reg_addr, TCRI_CNT_LO_IDX) && !reg_wr)
        |=> (st_reg.temp == $past(st_reg.count[15:8]));
  endproperty
  a_low_read_snap: assert property (p_low_read_snap) else $error("high byte not latched");

  property p_block_next_tick;
    @(posedge sys_clk) disable iff (sys_rst)
      (st_reg.block_match && timer_tick && !compare_flag_clear[0] && !st_reg.cmp_flag_a)
        |=> !st_reg.cmp_flag_a;
  endproperty
  a_block_next_tick: assert property (p_block_next_tick) else $error("match not blocked");

  property p_match_8bit;
    @(posedge sys_clk) disable iff (sys_rst)
      (!wide && match_ok && (st_reg.count[7:0] == st_reg.cmp_b)) |=> st_reg.cmp_flag_b;
  endproperty
  a_match_8bit: assert property (p_match_8bit) else $error("8-bit match b lost");

  property p_wide_no_flag_b;
    @(posedge sys_clk) disable iff (sys_rst)
      wide |=> !$rose(st_reg.cmp_flag_b);
  endproperty
  a_wide_no_flag_b: assert property (p_wide_no_flag_b) else $error("flag b set in 16-bit");

  property p_clear_on_match;
    @(posedge sys_clk) disable iff (sys_rst)
      (wave == TCRI_WAVE_CLEAR_ON_MATCH && timer_tick && match_a && !wr_cnt_lo)
        |=> (st_reg.count == TCRI_COUNT_RESET);
  endproperty
  a_clear_on_match: assert property (p_clear_on_match) else $error("counter not cleared");

  property p_capture_copy;
    @(posedge sys_clk) disable iff (sys_rst)
      (cap_mode && cap.capture_event)
        |=> (st_reg.cap_flag && st_reg.cmp_a == $past(st_reg.count[7:0]));
  endproperty
  a_capture_copy: assert property (p_capture_copy) else $error("capture not taken");

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == TCRI_CTRL_A_IDX) |=> (st_reg.rdata[2:1] == 2'b00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

  property p_narrow_high_zero;
    @(posedge sys_clk) disable iff (sys_rst)
      (!wide && timer_tick && !wr_cnt_lo) |=> (st_reg.count[15:8] == 8'h00);
  endproperty
  a_narrow_high_zero: assert property (p_narrow_high_zero) else $error("8-bit count overran");

  property p_ctrl_c_zero;
    @(posedge sys_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == TCRI_CTRL_C_IDX) |=> (st_reg.rdata[7:2] == 6'h00);
  endproperty
  a_ctrl_c_zero: assert property (p_ctrl_c_zero) else $error("control c upper bits nonzero");

  property p_capture_no_match;
    @(posedge sys_clk) disable iff (sys_rst)
      cap_mode |=> !$rose(st_reg.cmp_flag_a);
  endproperty
  a_capture_no_match: assert property (p_capture_no_match) else $error("match in capture mode");

  // a held flag with the enable up keeps the request line raised
  property p_irq_follow;
    @(posedge sys_clk) disable iff (sys_rst)
      (st_reg.cap_flag && !capture_flag_clear && capture_interrupt_enable)
        |=> st_reg.cap_irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("capture request missing");

endmodule

// File: tb/tcri_cpu_model.sv
`timescale 1ns/1ns
// ********************************************************
// processor core model on the byte-wide register port
// ********************************************************
module tcri_cpu_model (
  input  wire logic                            sys_clk,
  output logic      [tcri_pkg::TCRI_ADDR_W-1:0] reg_addr,
  output logic                                 reg_wr,
  output logic                                 reg_rd,
  output logic      [7:0]                      reg_wdata,
  input  wire logic [7:0]                      reg_rdata
);
  import tcri_pkg::*;

  // idle bus at time zero
  initial begin
    reg_addr  = 3'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // one byte write; strobe stands for exactly one taken edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d; // released data must not keep the last value
  endtask

  // one byte read; data sampled mid-cycle to stay clear of the edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask

  // reserved bit 3 is always written as zero
  task automatic wr_ctl_a(input logic [7:0] d);
    wr(TCRI_CTRL_A_IDX, d & 8'hf7);
  endtask

  // pairs run back to back with nothing in between, as with interrupts off
  task automatic wr16(input logic [2:0] lo, input logic [15:0] v);
    wr(lo + 3'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask

  task automatic rd16(input logic [2:0] lo, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 3'h1, v[15:8]);
  endtask
endmodule

// File: tb/tcri_timer_test.sv
`timescale 1ns/1ns
module tcri_timer_test;
  import tcri_pkg::*;

  logic                   sys_clk;
  logic                   sys_rst;
  logic [TCRI_ADDR_W-1:0] reg_addr;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [7:0]             reg_wdata;
  logic [7:0]             reg_rdata;
  logic                   tick;
  logic [2:0]             src;
  logic                   irq_en;
  logic                   cap_clr;
  logic [1:0]             cmp_clr;
  logic                   cap_flag;
  logic                   flag_a;
  logic                   flag_b;
  logic                   cap_irq;
  int                     fail_count;
  int                     compares;
  int                     i;
  int                     s;
  int                     k;
  logic [7:0]             b;
  logic [15:0]            w;

  tcri_cpu_model i_cpu (
    .sys_clk   (sys_clk),
    .reg_addr  (reg_addr),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata)
  );

  tcri_timer i_dut (
    .sys_clk                  (sys_clk),
    .sys_rst                  (sys_rst),
    .reg_addr                 (reg_addr),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_wdata                (reg_wdata),
    .reg_rdata                (reg_rdata),
    .timer_tick               (tick),
    .capture_pin              (src[0]),
    .serial_rx_done_source    (src[1]),
    .serial_tx_done_source    (src[2]),
    .capture_interrupt_enable (irq_en),
    .capture_flag_clear       (cap_clr),
    .compare_flag_clear       (cmp_clr),
    .capture_flag             (cap_flag),
    .compare_flag_a           (flag_a),
    .compare_flag_b           (flag_b),
    .capture_irq              (cap_irq)
  );

  // 20 mhz system clock
  always #25 sys_clk = ~sys_clk;

  // ********************************************************
  // helpers
  // ********************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // let flag updates land before looking at them
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // timer ticks spaced apart so each is a separate prescaled pulse
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      tick <= 1'b1;
      @(posedge sys_clk);
      tick <= 1'b0;
    end
  endtask

  // one pulse on each chosen clear line, so each compare clear is tried alone too
  task automatic clr_sel(input logic c, input logic [1:0] m);
    @(posedge sys_clk);
    cap_clr <= c;
    cmp_clr <= m;
    @(posedge sys_clk);
    cap_clr <= 1'b0;
    cmp_clr <= 2'h0;
  endtask

  task automatic clr_flags();
    clr_sel(1'b1, 2'h3);
  endtask

  // high pulse of n cycles on one capture source
  task automatic pulse(input int idx, input int n);
    @(posedge sys_clk);
    src[idx] <= 1'b1;
    repeat (n) @(posedge sys_clk);
    src[idx] <= 1'b0;
  endtask

  task automatic complete_run();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    complete_run();
  end

  // ********************************************************
  // test sequence
  // ********************************************************
  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    tick = 1'b0;
    src = 3'h0;
    irq_en = 1'b1;
    cap_clr = 1'b0;
    cmp_clr = 2'h0;
    fail_count = 0;
    compares = 0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // reset values, unmapped indices and read-as-zero bits
    for (i = 0; i < 8; i++) begin
      i_cpu.rd(i[2:0], b);
      chk({8'h00, b}, 16'h0000);
    end
    i_cpu.wr(3'h6, 8'h5a);
    i_cpu.rd(3'h6, b);
    chk({8'h00, b}, 16'h0000);
    i_cpu.wr_ctl_a(8'hf7);
    i_cpu.rd(TCRI_CTRL_A_IDX, b);
    chk({8'h00, b}, 16'h00f1);
    i_cpu.wr(TCRI_CTRL_C_IDX, 8'hff);
    i_cpu.rd(TCRI_CTRL_C_IDX, b);
    chk({8'h00, b}, 16'h0003);
    $display("test registers done");
    // 16-bit access through the shared holding byte
    i_cpu.wr_ctl_a(8'h80);
    i_cpu.wr16(TCRI_CNT_LO_IDX, 16'h01ff);
    i_cpu.rd16(TCRI_CNT_LO_IDX, w);
    chk(w, 16'h01ff);
    i_cpu.wr16(TCRI_CNT_LO_IDX, 16'h1255);
    i_cpu.wr(TCRI_CMP_A_IDX, 8'h56); // high byte reused without rewrite
    i_cpu.rd16(TCRI_CMP_A_IDX, w);
    chk(w, 16'h1256);
    clr_flags();
    ticks(2);
    settle(2);
    chk({15'h0, flag_a}, 16'h0001);
    chk({15'h0, flag_b}, 16'h0000);
    // counter written equal to compare: next tick must not match
    i_cpu.wr16(TCRI_CNT_LO_IDX, 16'h1256);
    clr_flags();
    ticks(1);
    settle(2);
    chk({15'h0, flag_a}, 16'h0000);
    i_cpu.rd16(TCRI_CNT_LO_IDX, w);
    chk(w, 16'h1257);
    $display("test sixteen bit done");
    // clear-on-match mode
    i_cpu.wr_ctl_a(8'h81);
    i_cpu.wr16(TCRI_CNT_LO_IDX, 16'h1255);
    ticks(2);
    i_cpu.rd16(TCRI_CNT_LO_IDX, w);
    chk(w, 16'h0000);
    $display("test clear on match done");
    // 8-bit mode, both compare units on the low byte
    i_cpu.wr_ctl_a(8'h00);
    i_cpu.wr(TCRI_CMP_A_IDX, 8'h10);
    i_cpu.wr(TCRI_CMP_B_IDX, 8'h11);
    i_cpu.wr(TCRI_CNT_LO_IDX, 8'h0f);
    clr_flags();
    ticks(2);
    settle(2);
    chk({14'h0, flag_b, flag_a}, 16'h0001);
    ticks(1);
    settle(2);
    chk({14'h0, flag_b, flag_a}, 16'h0003);
    clr_sel(1'b0, 2'h1);
    settle(1);
    chk({14'h0, flag_b, flag_a}, 16'h0002);
    clr_sel(1'b0, 2'h2);
    settle(1);
    chk({14'h0, flag_b, flag_a}, 16'h0000);
    $display("test eight bit done");
    // capture: every source code against every source input
    i_cpu.wr_ctl_a(8'hd0);
    i_cpu.wr16(TCRI_CNT_LO_IDX, 16'h0abc);
    for (s = 0; s < 4; s++) begin
      i_cpu.wr(TCRI_CTRL_C_IDX, s[7:0]);
      for (k = 0; k < 3; k++) begin
        clr_flags();
        pulse(k, 6);
        settle(12);
        chk({14'h0, cap_irq, cap_flag}, {14'h0, {2{s == k}}});
      end
    end
    i_cpu.wr(TCRI_CTRL_C_IDX, 8'h00);
    i_cpu.rd16(TCRI_CMP_A_IDX, w);
    chk(w, 16'h0abc);
    // falling edge select, interrupt disabled
    @(posedge sys_clk);
    irq_en <= 1'b0;
    i_cpu.wr_ctl_a(8'hc0);
    clr_flags();
    @(posedge sys_clk);
    src[0] <= 1'b1;
    settle(12);
    chk({15'h0, cap_flag}, 16'h0000);
    @(posedge sys_clk);
    src[0] <= 1'b0;
    settle(12);
    chk({14'h0, cap_irq, cap_flag}, 16'h0001);
    // noise filter rejects a short glitch, passes a steady level
    @(posedge sys_clk);
    irq_en <= 1'b1;
    i_cpu.wr_ctl_a(8'hf0);
    clr_flags();
    pulse(0, 2);
    settle(14);
    chk({14'h0, cap_irq, cap_flag}, 16'h0000);
    pulse(0, 8);
    settle(14);
    chk({14'h0, cap_irq, cap_flag}, 16'h0003);
    $display("test capture done");
    // second reset in mid-run returns registers and flags to zero
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    i_cpu.rd(TCRI_CTRL_A_IDX, b);
    chk({8'h00, b}, 16'h0000);
    i_cpu.rd16(TCRI_CMP_A_IDX, w);
    chk(w, 16'h0000);
    chk({12'h0, cap_irq, cap_flag, flag_b, flag_a}, 16'h0000);
    $display("test reset done");
    complete_run();
  end
endmodule
